// ===== core/ped_paging_entry_decode.sv
// AHB-Lite register block that decodes and checks paging entries
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`default_nettype none
module ped_paging_entry_decode #(
	parameter int unsigned PHYS_ADDR_WIDTH = ped_pkg::PHYS_W_MAX
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// AHB-Lite address phase
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	// AHB-Lite data phase
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		ped_pkg::ped_phase_t phase;
		logic wr_pend;
		logic [7:0] wr_ofs;
		ped_pkg::ped_ctrl_t ctrl;
		logic [31:0] entry_lo;
		logic [31:0] entry_hi;
		logic [31:0] lin;
		ped_pkg::ped_cmd_t cmd;
		ped_pkg::ped_status_t status;
		logic [51:0] addr;
		logic acc_w;
		logic acc_u;
		logic acc_x;
		logic [31:0] rdata;
		logic readyout;
		logic resp;
	} ped_state_t;

	localparam ped_state_t ST_RST = '{
		phase: ped_pkg::ST_IDLE,
		wr_pend: 1'b0,
		wr_ofs: 8'h00,
		ctrl: ped_pkg::ped_ctrl_t'(ped_pkg::REG_RST),
		entry_lo: ped_pkg::REG_RST,
		entry_hi: ped_pkg::REG_RST,
		lin: ped_pkg::REG_RST,
		cmd: ped_pkg::ped_cmd_t'(ped_pkg::REG_RST),
		status: ped_pkg::ped_status_t'(ped_pkg::REG_RST),
		addr: 52'h0_0000_0000_0000,
		acc_w: 1'b1,
		acc_u: 1'b1,
		acc_x: 1'b1,
		rdata: ped_pkg::REG_RST,
		readyout: 1'b1,
		resp: ped_pkg::HRESP_OKAY
	};

	ped_state_t q, d;
	ped_fields_if fld ();
	logic [63:0] entry;
	logic addr_phase;
	logic usable, lvl3, rw, ru, rx, wr_deny, usr_deny, fx_deny, mapped, ok;
	logic [31:0] rv;

	assign entry = {q.entry_hi, q.entry_lo};
	// Only NONSEQ is ever issued; SEQ would be taken the same way
	assign addr_phase = hsel && hready && htrans[1];

	////////////////////////////////////////////////////////////////////////
	// Field decoder

	ped_entry_decode #(
		.PHYS_ADDR_WIDTH(PHYS_ADDR_WIDTH)
	) u_dec (
		.entry(entry),
		.is_table_entry(q.cmd.table_entry),
		.no_execute_enable(q.ctrl.no_execute_enable),
		.global_pages_enable(q.ctrl.global_pages_enable),
		.mtt_supported(q.ctrl.mtt_supported),
		.f(fld)
	);

	////////////////////////////////////////////////////////////////////////
	// Access rights

	// A table entry inherits the rights of the directory entry before it
	always_comb begin
		usable = fld.present && !fld.rsvd_fault;
		lvl3 = (q.ctrl.current_privilege_level == ped_pkg::PRIV_USER);
		rw = (q.cmd.table_entry ? q.acc_w : 1'b1) && fld.writable;
		ru = (q.cmd.table_entry ? q.acc_u : 1'b1) && fld.user_ok;
		rx = (q.cmd.table_entry ? q.acc_x : 1'b1) && !fld.execute_disable_flag;
		// Supervisor writes pass read-only pages unless protection is on
		wr_deny = q.cmd.write && !rw
			&& (lvl3 || q.ctrl.supervisor_write_protect_enable);
		usr_deny = lvl3 && !ru;
		fx_deny = q.cmd.fetch && !rx;
		mapped = usable && (fld.large_page || fld.small_page);
		ok = mapped && !wr_deny && !usr_deny && !fx_deny;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d = q;
		rv = ped_pkg::REG_RST;
		// Decode of the last command, one cycle after its write
		case (q.phase)
			ped_pkg::ST_EVAL: begin
				d.phase = ped_pkg::ST_IDLE;
				d.status = ped_pkg::ped_status_t'(ped_pkg::REG_RST);
				d.status.done = 1'b1;
				d.status.present = fld.present;
				d.status.large_page = fld.large_page && usable;
				d.status.table_ref = fld.table_ref && usable;
				d.status.small_page = fld.small_page && usable;
				d.status.rsvd_fault = fld.rsvd_fault;
				d.status.page_fault = !usable;
				d.status.allowed = ok;
				d.status.blocked = mapped && !ok;
				d.status.writable = fld.writable;
				d.status.user_ok = fld.user_ok;
				d.status.write_through_ctl = fld.write_through_ctl;
				d.status.cache_disable_ctl = fld.cache_disable_ctl;
				d.status.accessed = fld.accessed;
				d.status.dirty = fld.dirty;
				d.status.global_page = fld.global_page;
				d.status.memory_type_table_index = fld.memory_type_table_index;
				d.status.execute_disable_flag = fld.execute_disable_flag;
				d.addr = 52'h0_0000_0000_0000;
				if (usable && fld.large_page) begin
					d.addr = {fld.base_addr[51:21], q.lin[20:0]};
				end else if (usable && fld.small_page) begin
					d.addr = {fld.base_addr[51:12], q.lin[11:0]};
				end else if (usable && fld.table_ref) begin
					d.addr = {fld.base_addr[51:12],
						q.lin[ped_pkg::LIN_IDX_HI:ped_pkg::LIN_IDX_LO],
						ped_pkg::ENTRY_ALIGN};
				end
				// Every directory entry reseeds the rights for the table; only a usable table reference grants any
				if (!q.cmd.table_entry) begin
					d.acc_w = usable && fld.table_ref && fld.writable;
					d.acc_u = usable && fld.table_ref && fld.user_ok;
					d.acc_x = usable && fld.table_ref && !fld.execute_disable_flag;
				end
			end
			default: begin
				d.phase = ped_pkg::ST_IDLE;
			end
		endcase
		// Data phase of a write; a new command restarts the decode
		d.wr_pend = 1'b0;
		if (q.wr_pend) begin
			case (q.wr_ofs)
				ped_pkg::OFS_CTRL: begin
					d.ctrl = ped_pkg::ped_ctrl_t'(hwdata & ped_pkg::CTRL_WMASK);
				end
				ped_pkg::OFS_ENTRY_LO: begin
					d.entry_lo = hwdata;
				end
				ped_pkg::OFS_ENTRY_HI: begin
					d.entry_hi = hwdata;
				end
				ped_pkg::OFS_LIN: begin
					d.lin = hwdata;
				end
				ped_pkg::OFS_CMD: begin
					d.cmd = ped_pkg::ped_cmd_t'(hwdata & ped_pkg::CMD_WMASK);
					d.status.done = 1'b0;
					d.phase = ped_pkg::ST_EVAL;
				end
				default: begin
				end
			endcase
		end
		// Address phase; reads see a write finishing in the same cycle
		if (addr_phase && hwrite) begin
			d.wr_pend = 1'b1;
			d.wr_ofs = haddr[7:0];
		end
		if (addr_phase && !hwrite) begin
			case (haddr[7:0])
				ped_pkg::OFS_CTRL: rv = d.ctrl;
				ped_pkg::OFS_ENTRY_LO: rv = d.entry_lo;
				ped_pkg::OFS_ENTRY_HI: rv = d.entry_hi;
				ped_pkg::OFS_LIN: rv = d.lin;
				ped_pkg::OFS_CMD: rv = d.cmd;
				ped_pkg::OFS_STATUS: rv = d.status;
				ped_pkg::OFS_ADDR_LO: rv = d.addr[31:0];
				ped_pkg::OFS_ADDR_HI: rv = {12'h000, d.addr[51:32]};
				default: rv = ped_pkg::REG_RST;
			endcase
			d.rdata = rv;
		end
		// Never stalls; every answer is OKAY
		d.readyout = 1'b1;
		d.resp = ped_pkg::HRESP_OKAY;
	end

	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end

	assign hrdata = q.rdata;
	assign hreadyout = q.readyout;
	assign hresp = q.resp;

	////////////////////////////////////////////////////////////////////////
	// Checks

	logic ev;
	assign ev = (q.phase == ped_pkg::ST_EVAL);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	a_large_page_map: assert property (
		ev && !q.cmd.table_entry && entry[0] && entry[7] && !fld.rsvd_fault
		|=> q.status.large_page && !q.status.table_ref && q.status.done)
		else $error("large page entry not reported as large page");

	a_table_ref_kind: assert property (
		ev && !q.cmd.table_entry && entry[0] && !entry[7] && !fld.rsvd_fault
		|=> q.status.table_ref && !q.status.large_page && !q.status.dirty)
		else $error("table reference entry misclassified");

	a_high_rsvd_bit: assert property (
		ev && entry[0] && entry[PHYS_ADDR_WIDTH % 63]
		&& (PHYS_ADDR_WIDTH < 63)
		|=> q.status.rsvd_fault && q.status.page_fault)
		else $error("set bit above physical width not flagged");

	a_large_mid_rsvd: assert property (
		ev && !q.cmd.table_entry && entry[0] && entry[7] && (|entry[20:13])
		|=> q.status.rsvd_fault && !q.status.large_page)
		else $error("large page bits 20:13 not flagged");

	a_absent_faults: assert property (
		ev && !entry[0]
		|=> q.status.page_fault && !q.status.allowed && (q.addr == '0))
		else $error("absent entry did not fault");

	a_exec_dis_rsvd: assert property (
		ev && entry[0] && entry[63] && !q.ctrl.no_execute_enable
		|=> q.status.rsvd_fault && !q.status.execute_disable_flag)
		else $error("bit 63 not reserved with no-execute off");

	a_fetch_blocked: assert property (
		ev && entry[0] && entry[63] && q.ctrl.no_execute_enable && q.cmd.fetch
		|=> !q.status.allowed)
		else $error("fetch allowed from execute-disabled page");

	a_global_gate: assert property (
		ev && !q.ctrl.global_pages_enable |=> !q.status.global_page)
		else $error("global marker honoured with global pages off");

	a_user_refused: assert property (
		ev && (q.ctrl.current_privilege_level == 2'h3) && !entry[2]
		|=> !q.status.allowed)
		else $error("privilege 3 access allowed on supervisor page");

	a_write_refused: assert property (
		ev && q.cmd.write && !entry[1] && q.ctrl.supervisor_write_protect_enable
		|=> !q.status.allowed)
		else $error("write allowed on read-only page with protection on");

	a_large_address: assert property (
		ev && q.status.done == 1'b0 ##1 q.status.large_page
		|-> q.addr[20:0] == $past(q.lin[20:0])
		&& q.addr[51:21] == 31'(({$past(entry[51:21]), 21'h00_0000}
		& ((52'h1 << PHYS_ADDR_WIDTH) - 52'h1)) >> 21))
		else $error("large page address not frame plus linear 20:0");

	a_entry_address: assert property (
		ev ##1 q.status.table_ref
		|-> q.addr[11:3] == $past(q.lin[20:12]) && q.addr[2:0] == 3'h0)
		else $error("table entry address not built from linear 20:12");

	a_small_mtt_rsvd: assert property (
		ev && q.cmd.table_entry && entry[0] && entry[7] && !q.ctrl.mtt_supported
		|=> q.status.rsvd_fault)
		else $error("small page bit 7 not reserved without type table");

	a_cmd_to_done: assert property (
		q.wr_pend && (q.wr_ofs == ped_pkg::OFS_CMD) |=> !q.status.done ##1 q.status.done)
		else $error("decode did not complete two cycles after command");

	a_large_frame_cut: assert property (
		ev ##1 q.status.large_page |-> (q.addr >> PHYS_ADDR_WIDTH) == 52'h0_0000_0000_0000)
		else $error("large page frame not cut to the physical width");

	a_large_type_idx: assert property (
		ev && !q.cmd.table_entry && entry[0] && entry[7] && q.ctrl.mtt_supported
		|=> q.status.memory_type_table_index == $past(entry[12]))
		else $error("large page bit 12 not used as type index");

	a_cache_ctl: assert property (
		ev |=> q.status.write_through_ctl == $past(entry[3])
		&& q.status.cache_disable_ctl == $past(entry[4]))
		else $error("cache controls not taken from bits 3 and 4");

	a_rights_export: assert property (
		ev |=> q.status.writable == $past(entry[1]) && q.status.user_ok == $past(entry[2]))
		else $error("writable or user right not taken from bits 1 and 2");

	a_accessed_bit: assert property (
		ev |=> q.status.accessed == $past(entry[5]))
		else $error("accessed flag not taken from bit 5");

	a_dirty_map: assert property (
		ev && entry[0] && (q.cmd.table_entry || entry[7])
		|=> q.status.dirty == $past(entry[6]))
		else $error("dirty flag not taken from bit 6 of a mapping entry");

	a_table_ignores: assert property (
		ev && !q.cmd.table_entry && entry[0] && !entry[7]
		|=> !q.status.dirty && !q.status.global_page && !q.status.memory_type_table_index)
		else $error("table reference entry used an ignored bit");

	a_table_base: assert property (
		ev ##1 q.status.table_ref
		|-> q.addr[51:12] == 40'(({$past(entry[51:12]), 12'h000}
		& ((52'h1 << PHYS_ADDR_WIDTH) - 52'h1)) >> 12))
		else $error("page table base not taken from bits 51:12");

	a_small_frame: assert property (
		ev ##1 q.status.small_page
		|-> q.addr[11:0] == $past(q.lin[11:0])
		&& q.addr[51:12] == 40'(({$past(entry[51:12]), 12'h000}
		& ((52'h1 << PHYS_ADDR_WIDTH) - 52'h1)) >> 12))
		else $error("small page address not frame plus linear 11:0");

	a_small_type_idx: assert property (
		ev && q.cmd.table_entry && entry[0] && q.ctrl.mtt_supported
		|=> q.status.memory_type_table_index == $past(entry[7]))
		else $error("small page bit 7 not used as type index");

	// A table entry may not widen the write right its directory gave
	a_inherit_write: assert property (
		ev && q.cmd.table_entry && q.cmd.write && !q.acc_w
		&& (q.ctrl.current_privilege_level == 2'h3)
		|=> !q.status.allowed)
		else $error("table entry write allowed past read-only directory");
endmodule
`default_nettype wire

// ===== inc/ped_pkg.sv
// Package of constants and types for the paging entry decoder
//
// How it works
// - Directory entry maps large page: present and size-select
// - Directory bit 7 selects page versus table
// - Large frame from bits width-1 down to 21
// - High reserved bits and 20:13 flag violation
// - Large bit 12 is type index or reserved
// - Bits 3 and 4 give cache controls
// - Bit 1 clear may refuse writes
// - Bit 2 clear refuses privilege-3 accesses
// - Bit 5 is the accessed flag
// - Bit 6 dirty in mapping entries only
// - Bit 8 global only with global pages
// - Bit 63 execute-disable or reserved per enable
// - Table-referencing directory ignores bits 11:8, 6
// - Table base from bits width-1 down to 12
// - Table entry maps small page when present
// - Small bit 7 is type index or reserved
// - Bits 11:9 of mapping entries are ignored
// - Reference proceeds only if accumulated rights allow
// - Absent or reserved entry faults, never used
// - Large address joins frame and linear 20:0
// - Table entry address from base and linear 20:12
// - Physical width is a parameter up to 52
`default_nettype none
package ped_pkg;
	// Widths
	localparam int unsigned PHYS_W_MAX = 52;
	localparam int unsigned ENTRY_W = 64;
	// Entry bit positions
	localparam int unsigned B_PRESENT = 0;
	localparam int unsigned B_WRITABLE = 1;
	localparam int unsigned B_USER = 2;
	localparam int unsigned B_WT = 3;
	localparam int unsigned B_CD = 4;
	localparam int unsigned B_ACCESSED = 5;
	localparam int unsigned B_DIRTY = 6;
	localparam int unsigned B_PAGE_SIZE = 7;
	localparam int unsigned B_SM_MTT = 7;
	localparam int unsigned B_GLOBAL = 8;
	localparam int unsigned B_LG_MTT = 12;
	localparam int unsigned B_LG_RSV_LO = 13;
	localparam int unsigned B_LG_RSV_HI = 20;
	localparam int unsigned B_LG_FRAME = 21;
	localparam int unsigned B_SM_FRAME = 12;
	localparam int unsigned B_RSV_TOP = 62;
	localparam int unsigned B_EXEC_DIS = 63;
	// Linear address fields and entry stride
	localparam int unsigned LIN_IDX_LO = 12;
	localparam int unsigned LIN_IDX_HI = 20;
	localparam logic [2:0] ENTRY_ALIGN = 3'h0;
	localparam logic [1:0] PRIV_USER = 2'h3;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ENTRY_LO = 8'h04;
	localparam logic [7:0] OFS_ENTRY_HI = 8'h08;
	localparam logic [7:0] OFS_LIN = 8'h0c;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_ADDR_LO = 8'h18;
	localparam logic [7:0] OFS_ADDR_HI = 8'h1c;
	// Writable bits and reset values
	localparam logic [31:0] CTRL_WMASK = 32'h0000_003f;
	localparam logic [31:0] CMD_WMASK = 32'h0000_0007;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	// Control register layout
	typedef struct packed {
		logic [25:0] zero;
		logic [1:0] current_privilege_level;
		logic supervisor_write_protect_enable;
		logic mtt_supported;
		logic global_pages_enable;
		logic no_execute_enable;
	} ped_ctrl_t;
	// Command register layout; a write starts one decode
	typedef struct packed {
		logic [28:0] zero;
		logic fetch;
		logic write;
		logic table_entry;
	} ped_cmd_t;
	// Status register layout
	typedef struct packed {
		logic [13:0] zero;
		logic execute_disable_flag;
		logic memory_type_table_index;
		logic global_page;
		logic dirty;
		logic accessed;
		logic cache_disable_ctl;
		logic write_through_ctl;
		logic user_ok;
		logic writable;
		logic blocked;
		logic allowed;
		logic page_fault;
		logic rsvd_fault;
		logic small_page;
		logic table_ref;
		logic large_page;
		logic present;
		logic done;
	} ped_status_t;
	typedef enum logic {ST_IDLE, ST_EVAL} ped_phase_t;
endpackage
`default_nettype wire

// ===== inc/ped_fields_if.sv
// Decoded entry fields passed from the field decoder to the register block
`default_nettype none
interface ped_fields_if;
	logic present, large_page, table_ref, small_page, rsvd_fault;
	logic writable, user_ok, write_through_ctl, cache_disable_ctl;
	logic accessed, dirty, global_page, memory_type_table_index;
	logic execute_disable_flag;
	logic [51:0] base_addr;
	modport dec (output present, large_page, table_ref, small_page, rsvd_fault,
		writable, user_ok, write_through_ctl, cache_disable_ctl, accessed,
		dirty, global_page, memory_type_table_index, execute_disable_flag, base_addr);
	modport use_side (input present, large_page, table_ref, small_page, rsvd_fault,
		writable, user_ok, write_through_ctl, cache_disable_ctl, accessed,
		dirty, global_page, memory_type_table_index, execute_disable_flag, base_addr);
endinterface
`default_nettype wire

// ===== core/ped_entry_decode.sv
// Combinational field decoder for one directory or table entry
`default_nettype none
module ped_entry_decode #(
	parameter int unsigned PHYS_ADDR_WIDTH = ped_pkg::PHYS_W_MAX
) (
	// Entry and its kind
	input wire logic [63:0] entry,
	input wire logic is_table_entry,
	// Mode enables
	input wire logic no_execute_enable,
	input wire logic global_pages_enable,
	input wire logic mtt_supported,
	// Decoded fields
	ped_fields_if.dec f
);
	logic [63:0] hi_rsvd;
	logic [51:0] addr_keep;
	logic pres, dir, lg, sm, maps;

	// Masks from the implemented width
	always_comb begin
		hi_rsvd = '0;
		addr_keep = '0;
		for (int i = 0; i < 64; i++) begin
			hi_rsvd[i] = (i >= PHYS_ADDR_WIDTH) && (i <= ped_pkg::B_RSV_TOP);
		end
		for (int i = 0; i < 52; i++) begin
			addr_keep[i] = (i < PHYS_ADDR_WIDTH);
		end
	end

	// Entry kind
	assign pres = entry[ped_pkg::B_PRESENT];
	assign dir = !is_table_entry;
	assign lg = pres && dir && entry[ped_pkg::B_PAGE_SIZE];
	assign sm = pres && is_table_entry;
	assign maps = lg || sm;

	// Kind and violation flags
	assign f.present = pres;
	assign f.large_page = lg;
	assign f.table_ref = pres && dir && !entry[ped_pkg::B_PAGE_SIZE];
	assign f.small_page = sm;
	assign f.rsvd_fault = pres && ((|(entry & hi_rsvd))
		|| (lg && (|entry[ped_pkg::B_LG_RSV_HI:ped_pkg::B_LG_RSV_LO]))
		|| (!no_execute_enable && entry[ped_pkg::B_EXEC_DIS])
		|| (!mtt_supported && lg && entry[ped_pkg::B_LG_MTT])
		|| (!mtt_supported && sm && entry[ped_pkg::B_SM_MTT]));

	// Rights and attributes; bits 11:9 never looked at
	assign f.writable = entry[ped_pkg::B_WRITABLE];
	assign f.user_ok = entry[ped_pkg::B_USER];
	assign f.write_through_ctl = entry[ped_pkg::B_WT];
	assign f.cache_disable_ctl = entry[ped_pkg::B_CD];
	assign f.accessed = entry[ped_pkg::B_ACCESSED];
	assign f.dirty = maps && entry[ped_pkg::B_DIRTY];
	assign f.global_page = maps && global_pages_enable && entry[ped_pkg::B_GLOBAL];
	assign f.memory_type_table_index = mtt_supported
		&& ((lg && entry[ped_pkg::B_LG_MTT]) || (sm && entry[ped_pkg::B_SM_MTT]));
	assign f.execute_disable_flag = pres && no_execute_enable && entry[ped_pkg::B_EXEC_DIS];

	// Frame or table base, cut to the implemented width
	assign f.base_addr = lg
		? ({entry[51:ped_pkg::B_LG_FRAME], 21'h00_0000} & addr_keep)
		: ({entry[51:ped_pkg::B_SM_FRAME], 12'h000} & addr_keep);
endmodule
`default_nettype wire

// ===== verification/ped_walker_model.sv
// Page walker model: AHB-Lite master that issues single word transfers
`default_nettype none
module ped_walker_model (
	// Clock
	input wire logic clk,
	// Master request
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	// Slave answer
	input wire logic [31:0] hrdata,
	input wire logic hready,
	input wire logic hresp
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WAIT_MAX = 64;
	//////////////////////////////////////////////////////////////////
	// Idle bus from time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
	end
	// Bounded wait for hready at a rising edge; ok drops if it never comes
	task automatic wait_ready(inout logic ok);
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1 && n < WAIT_MAX) begin
			n++;
			@(posedge clk);
		end
		if (hready !== 1'b1) begin
			ok = 1'b0;
		end
	endtask
	// One transfer; read data and response taken at the data phase edge
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic ok);
		ok = 1'b1;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= ped_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_ready(ok);
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready(ok);
		rd = hrdata;
		if (hresp !== ped_pkg::HRESP_OKAY) begin
			ok = 1'b0;
		end
		// Released data lines flip so stale data never looks valid
		hwdata <= ~wd;
	endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Testbench for the paging entry decoder register block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Narrow width so the reserved high field and masking are exercised
	localparam int unsigned PW = 40;
	localparam logic [31:0] LIN = 32'h1234_5678;
	localparam logic [31:0] M_ALL = 32'h3_ffff;
	localparam logic [31:0] M_FLT = 32'h0000_01ff;
	localparam logic [31:0] M_TBL = 32'h3_fe7f;
	localparam logic [31:0] M_SML = 32'h3_f9ff;
	logic clk, srst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	int fail_count, checked;
	//////////////////////////////////////////////////////////////////
	ped_paging_entry_decode #(.PHYS_ADDR_WIDTH(PW)) dut_u (.clk(clk), .srst(srst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp));
	ped_walker_model walker_u (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
		.hready(hreadyout), .hresp(hresp));
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Bus access; a hung bus ends the run at once
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		logic ok;
		walker_u.xfer(w, {24'h0, a}, d, r, ok);
		if (ok !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED bus answer expected okay seen timeout or error");
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		acc(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		acc(1'b0, a, 32'h0, r);
	endtask
	// One decode; expected address follows from the expected entry kind
	task automatic run(input logic [31:0] ctrl, input logic [63:0] e, input logic [31:0] cmd,
		input logic [31:0] exp, input logic [31:0] msk);
		logic [63:0] fm;
		logic [63:0] ea;
		logic [31:0] r;
		fm = (64'h1 << PW) - 64'h1;
		ea = 64'h0;
		if (exp[2]) ea = (e & fm & ~64'h1f_ffff) | LIN[20:0];
		if (exp[3]) ea = (e & fm & ~64'hfff) | {LIN[20:12], 3'h0};
		if (exp[4]) ea = (e & fm & ~64'hfff) | LIN[11:0];
		wr(ped_pkg::OFS_CTRL, ctrl);
		wr(ped_pkg::OFS_ENTRY_LO, e[31:0]);
		wr(ped_pkg::OFS_ENTRY_HI, e[63:32]);
		wr(ped_pkg::OFS_LIN, LIN);
		wr(ped_pkg::OFS_CMD, cmd);
		rd(ped_pkg::OFS_STATUS, r);
		chk("status", exp & msk, r & msk);
		rd(ped_pkg::OFS_ADDR_LO, r);
		chk("addr_lo", ea[31:0], r);
		rd(ped_pkg::OFS_ADDR_HI, r);
		chk("addr_hi", {12'h0, ea[51:32]}, r);
		$display("test done: entry %h cmd %h", e, cmd);
	endtask
	//////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] r;
		fail_count = 0;
		checked = 0;
		srst = 1'b1;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		// Reset values, writable bits, read-only and unmapped space
		rd(ped_pkg::OFS_CTRL, r);
		chk("ctrl reset", ped_pkg::REG_RST, r);
		wr(ped_pkg::OFS_CTRL, 32'hffff_ffff);
		rd(ped_pkg::OFS_CTRL, r);
		chk("ctrl mask", ped_pkg::CTRL_WMASK, r);
		wr(ped_pkg::OFS_STATUS, 32'hffff_ffff);
		rd(ped_pkg::OFS_STATUS, r);
		chk("status ro", ped_pkg::REG_RST, r);
		wr(8'h40, 32'h5a5a_5a5a);
		rd(8'h40, r);
		chk("unmapped", 32'h0, r);
		$display("test done: registers");
		// Large pages: fields, ignored bits and reserved bits; then an absent entry
		run(32'h07, 64'hab_cde0_1fff, 32'h0, 32'h1_fe87, M_ALL);
		run(32'h00, 64'hab_cde0_1fff, 32'h0, 32'h63, M_FLT);
		run(32'h00, 64'hab_cde0_01e7, 32'h0, 32'h6687, M_ALL);
		run(32'h04, 64'hab_cde0_2081, 32'h0, 32'h63, M_FLT);
		run(32'h04, 64'hab_cdf0_0081, 32'h0, 32'h63, M_FLT);
		run(32'h04, 64'h1ab_cde0_0083, 32'h0, 32'h63, M_FLT);
		run(32'h04, 64'h4000_00ab_cde0_0083, 32'h0, 32'h63, M_FLT);
		run(32'h00, 64'h8000_00ab_cde0_0083, 32'h0, 32'h63, M_FLT);
		run(32'h01, 64'h8000_00ab_cde0_0087, 32'h4, 32'h2_0707, M_ALL);
		run(32'h01, 64'h8000_00ab_cde0_0087, 32'h0, 32'h2_0687, M_ALL);
		run(32'h00, 64'hab_cde0_0086, 32'h0, 32'h41, M_FLT);
		// Write and user rights against privilege and write protect
		run(32'h30, 64'hab_cde0_0085, 32'h2, 32'h507, M_ALL);
		run(32'h08, 64'hab_cde0_0085, 32'h2, 32'h507, M_ALL);
		run(32'h00, 64'hab_cde0_0085, 32'h2, 32'h487, M_ALL);
		run(32'h30, 64'hab_cde0_0083, 32'h0, 32'h307, M_ALL);
		// Two-level walks: directory then table entry
		run(32'h07, 64'hab_3456_7f67, 32'h0, 32'h260b, M_TBL);
		run(32'h07, 64'h55_9abc_dfff, 32'h1, 32'h1_fe93, M_SML);
		run(32'h30, 64'hab_3456_7005, 32'h0, 32'h40b, M_TBL);
		run(32'h30, 64'h55_9abc_d007, 32'h3, 32'h113, M_FLT);
		run(32'h00, 64'h55_9abc_d081, 32'h1, 32'h63, M_FLT);
		report_and_stop();
	end
endmodule
`default_nettype wire
